//--- pkg/mmu_attr_consts.svh
`ifndef MMU_ATTR_CONSTS_SVH
`define MMU_ATTR_CONSTS_SVH
`define HW_ATTR_BITS 4
`define FSC_HW_UPD_REFUSED 6'h31
`define OFF_CTRL 12'h000
`define OFF_WALK 12'h004
`define OFF_FADDR 12'h008
`define OFF_STATUS 12'h00c
`define CTRL_RESET 32'h0000_0000
`define WALK_RESET 32'h0000_0000
`define CTRL_S1_AF 0
`define CTRL_S1_DIRTY 1
`define CTRL_S2_AF 2
`define CTRL_S2_DIRTY 3
`define CTRL_HW_ATTR_EN 4
`define CTRL_S1_MASK_LSB 8
`define CTRL_S2_MASK_LSB 12
`define WALK_S2_LSB 4
`define ST_SYNC 0
`define ST_ASYNC 1
`define ST_FSC_LSB 8
`endif

//--- pkg/mmu_attr_pkg.sv
package mmu_attr_pkg;
  // Cacheability of one level of Normal memory.
  typedef enum logic [1:0] {C_NC, C_WT, C_WB_NA, C_WB_AL} cache_t;
  // Shareability domains.
  typedef enum logic [1:0] {SH_NON, SH_OUTER, SH_INNER} share_t;
  // The four Device memory types.
  typedef enum logic [1:0] {D_NGNRNE, D_NGNRE, D_NGRE, D_GRE} dev_t;
  // Source of a translation completion.
  typedef enum logic [1:0] {SRC_L1I, SRC_L1D, SRC_L2, SRC_WALK} tc_src_t;
  // Operation behind a memory system response.
  typedef enum logic [3:0] {
    OP_WALK, OP_LOAD, OP_LOAD_ACQ, OP_ATOM_LD, OP_ATOM_CAS, OP_ATOM_SWP,
    OP_STORE, OP_ATOM_ST, OP_CMO, OP_TLB_INV, OP_IC
  } mem_op_t;
  // Interconnect response codes.
  typedef enum logic [1:0] {R_OK, R_EXOK, R_DERR, R_NDERR} chi_resp_t;
endpackage

//--- pkg/attr_map_if.sv
`timescale 1ns/100ps
interface attr_map_if
  import mmu_attr_pkg::*;
#(parameter int PW = 4);
  logic is_device, walk, stage2, hw_attr_en;
  cache_t inner, outer;
  share_t share_in, share_out;
  logic [PW-1:0] hw_attr_s1, hw_attr_s2, s1_mask, s2_mask, walk_s1, walk_s2, hw_attr;
  logic cacheable, outer_alloc;
  modport mapper(input is_device, walk, stage2, hw_attr_en, inner, outer,
    share_in, hw_attr_s1, hw_attr_s2, s1_mask, s2_mask, walk_s1, walk_s2,
    output share_out, hw_attr, cacheable, outer_alloc);
  modport user(output is_device, walk, stage2, hw_attr_en, inner, outer,
    share_in, hw_attr_s1, hw_attr_s2, s1_mask, s2_mask, walk_s1, walk_s2,
    input share_out, hw_attr, cacheable, outer_alloc);
endinterface

//--- hw/attr_map.sv
`timescale 1ns/100ps
module attr_map
  import mmu_attr_pkg::*;
#(
  parameter int PW = 4
) (
  // Attribute request and result.
  attr_map_if.mapper a
);
  // Only up to four attribute bits exist in the descriptors.
  if (PW < 1 || PW > 4) begin : g_bad_pw
    $error("attr_map: PW must be 1 to 4");
  end

  // Memory type and shareability mapping.
  always_comb begin
    a.cacheable = 1'b0;
    a.outer_alloc = 1'b0;
    a.share_out = SH_OUTER;
    if (a.is_device) begin
      // Device type passes through untouched by the caller.
      a.share_out = SH_OUTER;
    end else if (a.inner == C_NC || a.inner == C_WT ||
                 a.outer == C_NC || a.outer == C_WT) begin
      // Weak combinations collapse to non-cacheable.
      a.share_out = SH_OUTER;
    end else begin
      // Cached; outer allocation only when the outer level is write-back allocate.
      a.cacheable = 1'b1;
      a.outer_alloc = (a.outer == C_WB_AL);
      // Inner domain is widened because no inner-only domain exists.
      a.share_out = (a.share_in == SH_NON) ? SH_NON : SH_OUTER;
    end
  end

  // Each attribute bit is chosen on its own.
  for (genvar i = 0; i < PW; i++) begin : g_bit
    always_comb begin
      if (!a.hw_attr_en) begin
        a.hw_attr[i] = 1'b0;
      end else if (a.walk) begin
        // Walk accesses take the walk controls of their stage.
        a.hw_attr[i] = a.stage2 ? a.walk_s2[i] : a.walk_s1[i];
      end else if (a.stage2 && a.s2_mask[i]) begin
        a.hw_attr[i] = a.hw_attr_s2[i];
      end else if (a.s1_mask[i]) begin
        a.hw_attr[i] = a.hw_attr_s1[i];
      end else begin
        a.hw_attr[i] = 1'b0;
      end
    end
  end
endmodule

//--- hw/mmu_attr_abort.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "mmu_attr_consts.svh"
module mmu_attr_abort
  import mmu_attr_pkg::*;
#(
  parameter int AW = 32, // Width of physical and fault addresses.
  parameter int PW = `HW_ATTR_BITS
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Translation completion from lookup or walk.
  input wire logic tc_valid,
  input wire tc_src_t tc_src,
  input wire logic tc_fetch,
  input wire logic [AW-1:0] tc_pa,
  input wire logic [3:0] tc_perm,
  input wire logic tc_ns,
  input wire logic tc_fault,
  input wire logic [5:0] tc_fsc,
  input wire logic tc_stage2,
  // Hardware table update wanted by this completion.
  input wire logic tc_upd_af,
  input wire logic tc_upd_dirty,
  input wire logic tc_dirty_bit_modifier,
  input wire logic tc_tbl_normal,
  input wire cache_t tc_tbl_inner,
  input wire cache_t tc_tbl_outer,
  // Attributes of the access.
  input wire logic ma_device,
  input wire dev_t ma_dev_type,
  input wire cache_t ma_inner,
  input wire cache_t ma_outer,
  input wire share_t ma_share,
  input wire logic ma_walk,
  input wire logic [PW-1:0] ma_hw_attr_s1,
  input wire logic [PW-1:0] ma_hw_attr_s2,
  // Translation response.
  output logic tr_valid,
  output tc_src_t tr_src,
  output logic [AW-1:0] tr_pa,
  output logic [3:0] tr_perm,
  output logic tr_ns,
  output logic tr_abort,
  output logic tr_instr,
  output logic [5:0] data_fault_status_code,
  output logic [5:0] instr_fault_status_code,
  output logic tr_hw_update,
  // Transaction attributes.
  output logic bus_device,
  output dev_t bus_dev_type,
  output logic bus_cacheable,
  output logic bus_outer_alloc,
  output share_t bus_share,
  output logic [PW-1:0] bus_hw_attr,
  // Memory system response.
  input wire logic mr_valid,
  input wire mem_op_t mr_op,
  input wire logic mr_normal,
  input wire logic mr_excl,
  input wire chi_resp_t mr_resp,
  input wire logic mr_ecc_err,
  input wire logic [AW-1:0] mr_addr,
  // Abort reporting.
  output logic sync_abort,
  output logic async_abort,
  output logic [AW-1:0] fault_address_capture
);
  // The fault address is read back through one 32-bit register.
  if (AW < 1 || AW > 32) begin : g_bad_aw
    $error("mmu_attr_abort: AW must be 1 to 32");
  end

  logic [31:0] ctrl_reg; // Update enables and attribute masks.
  logic [31:0] walk_reg; // Walk attribute controls, stage 1 low.
  logic sync_seen_reg; // Sticky synchronous abort flag.
  logic async_seen_reg; // Sticky asynchronous abort flag.
  logic [5:0] last_fsc_reg; // Last non-zero abort status code.

  // Decodes an APB offset into a register hit.
  function automatic logic is_mapped(input logic [11:0] a);
    return a == `OFF_CTRL || a == `OFF_WALK || a == `OFF_FADDR ||
           a == `OFF_STATUS;
  endfunction

  // Tells whether a cacheability level is write-back.
  function automatic logic is_wb(input cache_t c);
    return c == C_WB_NA || c == C_WB_AL;
  endfunction

  // APB handshake: one wait state keeps pready and prdata from flops.
  logic apb_done;
  assign apb_done = psel && penable && pready;

  // Answer phase: pready rises one cycle into the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !is_mapped(paddr);
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `OFF_CTRL: prdata <= ctrl_reg;
          `OFF_WALK: prdata <= walk_reg;
          `OFF_FADDR: prdata <= 32'(fault_address_capture);
          `OFF_STATUS: begin
            prdata[`ST_SYNC] <= sync_seen_reg;
            prdata[`ST_ASYNC] <= async_seen_reg;
            prdata[`ST_FSC_LSB +: 6] <= last_fsc_reg;
          end
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      // The answer stands for exactly one cycle.
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software-written control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      walk_reg <= `WALK_RESET;
    end else if (apb_done && pwrite) begin
      if (paddr == `OFF_CTRL) begin
        ctrl_reg <= pwdata;
      end
      if (paddr == `OFF_WALK) begin
        walk_reg <= pwdata;
      end
    end
  end

  // Hardware update qualification.
  logic af_en, dirty_en, upd_want, tbl_wb, upd_refused, upd_go;
  always_comb begin
    // Both stages must allow the update when stage 2 is active.
    af_en = ctrl_reg[`CTRL_S1_AF] && (!tc_stage2 || ctrl_reg[`CTRL_S2_AF]);
    dirty_en = ctrl_reg[`CTRL_S1_DIRTY] &&
               (!tc_stage2 || ctrl_reg[`CTRL_S2_DIRTY]);
    // Dirty state is only hardware-managed with the modifier set.
    upd_want = (tc_upd_af && af_en) ||
               (tc_upd_dirty && dirty_en && tc_dirty_bit_modifier);
    // Atomic table writes need write-back table memory.
    tbl_wb = tc_tbl_normal && is_wb(tc_tbl_inner) && is_wb(tc_tbl_outer);
    upd_refused = upd_want && !tbl_wb;
    upd_go = upd_want && tbl_wb && !tc_fault;
  end

  // Translation response, one per completion whatever its source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_valid <= 1'b0;
      tr_src <= SRC_L1I;
      tr_pa <= '0;
      tr_perm <= 4'h0;
      tr_ns <= 1'b0;
      tr_abort <= 1'b0;
      tr_instr <= 1'b0;
      tr_hw_update <= 1'b0;
    end else begin
      tr_valid <= tc_valid;
      tr_hw_update <= tc_valid && upd_go;
      if (tc_valid) begin
        // Address, permissions and security state travel together.
        tr_src <= tc_src;
        tr_pa <= tc_pa;
        tr_perm <= tc_perm;
        tr_ns <= tc_ns;
        // Oversized blocks and overlapping entries add no fault.
        tr_abort <= tc_fault || upd_refused;
        tr_instr <= tc_fetch;
      end
    end
  end

  // Fault status codes, split by requester kind.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_fault_status_code <= 6'h00;
      instr_fault_status_code <= 6'h00;
    end else if (tc_valid) begin
      data_fault_status_code <= 6'h00;
      instr_fault_status_code <= 6'h00;
      // A walker fault outranks the refused update.
      if (tc_fault) begin
        if (tc_fetch) begin
          instr_fault_status_code <= tc_fsc;
        end else begin
          data_fault_status_code <= tc_fsc;
        end
      end else if (upd_refused) begin
        if (tc_fetch) begin
          instr_fault_status_code <= `FSC_HW_UPD_REFUSED;
        end else begin
          data_fault_status_code <= `FSC_HW_UPD_REFUSED;
        end
      end
    end
  end

  // Attribute mapping runs in the shared mapper.
  attr_map_if #(.PW(PW)) am ();
  assign am.is_device = ma_device;
  assign am.inner = ma_inner;
  assign am.outer = ma_outer;
  assign am.share_in = ma_share;
  assign am.walk = ma_walk;
  assign am.stage2 = tc_stage2;
  assign am.hw_attr_en = ctrl_reg[`CTRL_HW_ATTR_EN];
  assign am.hw_attr_s1 = ma_hw_attr_s1;
  assign am.hw_attr_s2 = ma_hw_attr_s2;
  assign am.s1_mask = ctrl_reg[`CTRL_S1_MASK_LSB +: PW];
  assign am.s2_mask = ctrl_reg[`CTRL_S2_MASK_LSB +: PW];
  assign am.walk_s1 = walk_reg[0 +: PW];
  assign am.walk_s2 = walk_reg[`WALK_S2_LSB +: PW];

  attr_map #(.PW(PW)) u_map (
    .a(am.mapper)
  );

  // Bus attributes are captured with each completion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_device <= 1'b0;
      bus_dev_type <= D_NGNRNE;
      bus_cacheable <= 1'b0;
      bus_outer_alloc <= 1'b0;
      bus_share <= SH_NON;
      bus_hw_attr <= '0;
    end else if (tc_valid) begin
      bus_device <= ma_device;
      bus_dev_type <= ma_dev_type;
      bus_cacheable <= am.cacheable;
      bus_outer_alloc <= am.outer_alloc;
      bus_share <= am.share_out;
      // Aliases with differing bits may send either value.
      bus_hw_attr <= am.hw_attr;
    end
  end

  // External abort classification.
  logic ext_err, excl_ld, excl_st, want_sync, want_async;
  always_comb begin
    // Bus errors and uncorrected ECC errors both count.
    ext_err = mr_resp == R_DERR || mr_resp == R_NDERR || mr_ecc_err;
    excl_ld = mr_excl && mr_op == OP_LOAD;
    excl_st = mr_excl && mr_op == OP_STORE;
    want_sync = 1'b0;
    want_async = 1'b0;
    if (excl_ld) begin
      // Any answer short of exclusive success aborts.
      want_sync = mr_normal && (mr_resp != R_EXOK || mr_ecc_err);
      want_async = !mr_normal && (mr_resp != R_EXOK || mr_ecc_err);
    end else if (excl_st) begin
      // Plain and exclusive success are both accepted.
      want_async = ext_err;
    end else if (ext_err) begin
      case (mr_op)
        OP_WALK, OP_LOAD_ACQ, OP_ATOM_LD, OP_ATOM_CAS, OP_ATOM_SWP:
          want_sync = 1'b1;
        OP_LOAD: begin
          want_sync = mr_normal;
          want_async = !mr_normal;
        end
        default: want_async = 1'b1;
      endcase
    end
  end

  // Abort pulses and fault address capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_abort <= 1'b0;
      async_abort <= 1'b0;
      fault_address_capture <= '0;
    end else begin
      sync_abort <= mr_valid && want_sync;
      async_abort <= mr_valid && want_async;
      if (mr_valid && want_sync) begin
        fault_address_capture <= mr_addr;
      end
    end
  end

  // Sticky status; a new event wins over a same-cycle clear.
  logic st_wr;
  assign st_wr = apb_done && pwrite && paddr == `OFF_STATUS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_seen_reg <= 1'b0;
      async_seen_reg <= 1'b0;
      last_fsc_reg <= 6'h00;
    end else begin
      if (mr_valid && want_sync) begin
        sync_seen_reg <= 1'b1;
      end else if (st_wr && pwdata[`ST_SYNC]) begin
        sync_seen_reg <= 1'b0;
      end
      if (mr_valid && want_async) begin
        async_seen_reg <= 1'b1;
      end else if (st_wr && pwdata[`ST_ASYNC]) begin
        async_seen_reg <= 1'b0;
      end
      if (tc_valid && tc_fault) begin
        last_fsc_reg <= tc_fsc;
      end else if (tc_valid && upd_refused) begin
        last_fsc_reg <= `FSC_HW_UPD_REFUSED;
      end
    end
  end

  // Checks on the block's own outputs.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_REFUSE_DATA: assert property (
    tc_valid && !tc_fetch && !tc_fault && upd_refused |=>
      tr_abort && data_fault_status_code == `FSC_HW_UPD_REFUSED && !tr_hw_update)
    else $error("refused data-side update not aborted");
  AST_REFUSE_FETCH: assert property (
    tc_valid && tc_fetch && !tc_fault && upd_refused |=>
      tr_abort && tr_instr && instr_fault_status_code == `FSC_HW_UPD_REFUSED)
    else $error("refused fetch update not an instruction abort");
  AST_UPD_GATED: assert property (
    tr_hw_update |-> $past(tc_dirty_bit_modifier && tc_upd_dirty ||
      tc_upd_af) && $past(ctrl_reg[`CTRL_S1_AF] || ctrl_reg[`CTRL_S1_DIRTY]))
    else $error("hardware update without enable");
  AST_ONE_RESP: assert property (
    tc_valid |=> tr_valid ##1 ($past(tc_valid) == tr_valid))
    else $error("response missing or extra");
  AST_RESP_FIELDS: assert property (
    tc_valid |=> tr_pa == $past(tc_pa) && tr_ns == $past(tc_ns) &&
      tr_perm == $past(tc_perm))
    else $error("response fields wrong");
  AST_FAULT_ABORT: assert property (
    tc_valid && tc_fault && !tc_fetch |=>
      tr_abort && data_fault_status_code == $past(tc_fsc))
    else $error("translation fault not raised");
  AST_ECC_ABORTS: assert property (
    mr_valid && mr_ecc_err |=> sync_abort || async_abort)
    else $error("ECC error produced no abort");
  AST_SYNC_CLASS: assert property (
    mr_valid && mr_resp == R_DERR && !mr_excl &&
      (mr_op == OP_WALK || mr_op == OP_ATOM_CAS) |=> sync_abort && !async_abort)
    else $error("walk or atomic error not synchronous");
  AST_SYNC_ADDR: assert property (
    sync_abort |-> fault_address_capture == $past(mr_addr))
    else $error("fault address not captured");
  AST_STORE_ASYNC: assert property (
    mr_valid && !mr_excl && mr_op == OP_STORE && mr_resp == R_NDERR |=>
      async_abort && !sync_abort)
    else $error("store error not asynchronous");
  AST_EXCL_LD: assert property (
    mr_valid && excl_ld && mr_normal && mr_resp == R_OK |=> sync_abort)
    else $error("exclusive load without success not aborted");
  AST_EXCL_ST_OK: assert property (
    mr_valid && excl_st && !mr_ecc_err && mr_resp inside {R_OK, R_EXOK} |=>
      !sync_abort && !async_abort)
    else $error("exclusive store success aborted");
  AST_DEV_OUTER: assert property (
    tc_valid && ma_device |=> bus_share == SH_OUTER && !bus_cacheable)
    else $error("device access not outer shareable");
  AST_HW_ATTR_OFF: assert property (
    tc_valid && !ctrl_reg[`CTRL_HW_ATTR_EN] |=> bus_hw_attr == '0)
    else $error("attribute bits sent while disabled");
  AST_APB_WAIT: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

  COV_REFUSED: cover property (tc_valid && upd_refused ##1 tr_abort);
  COV_SYNC: cover property (mr_valid && want_sync ##1 sync_abort);
  COV_ASYNC: cover property (mr_valid && want_async ##1 async_abort);
  COV_APB_WR: cover property (apb_done && pwrite && paddr == `OFF_CTRL);
endmodule

//--- bench/ic_resp_model.sv
`timescale 1ns/100ps
module ic_resp_model
  import mmu_attr_pkg::*;
#(
  parameter int AW = 32
) (
  // Clock.
  input wire logic pclk,
  // Response towards the block.
  output logic mr_valid,
  output mem_op_t mr_op,
  output logic mr_normal,
  output logic mr_excl,
  output chi_resp_t mr_resp,
  output logic mr_ecc_err,
  output logic [AW-1:0] mr_addr
);
  // Quiet from time zero, so the block never sees an unknown response.
  initial begin
    mr_valid = 1'b0;
    mr_op = OP_WALK;
    mr_normal = 1'b0;
    mr_excl = 1'b0;
    mr_resp = R_OK;
    mr_ecc_err = 1'b0;
    mr_addr = '0;
  end
  // One response after gap idle cycles; e packs op, normal, excl, code, ecc.
  // The address is scrambled once released, so a stale value never looks valid.
  task automatic respond(input logic [10:0] e, input logic [AW-1:0] a, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    mr_valid <= 1'b1;
    mr_op <= mem_op_t'(e[10:7]);
    mr_normal <= e[6];
    mr_excl <= e[5];
    mr_resp <= chi_resp_t'(e[4:3]);
    mr_ecc_err <= e[2];
    mr_addr <= a;
    @(posedge pclk);
    mr_valid <= 1'b0;
    mr_addr <= ~a;
  endtask
endmodule

//--- bench/mmu_attr_abort_tb.sv
`timescale 1ns/100ps
`include "mmu_attr_consts.svh"
module mmu_attr_abort_tb import mmu_attr_pkg::*;;
  // Ports of the block, named as the block names them.
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, tc_pa, tr_pa, mr_addr, fault_address_capture;
  logic tc_valid, tc_fetch, tc_ns, tc_fault, tc_stage2, tc_upd_af, tc_upd_dirty;
  logic tc_dirty_bit_modifier, tc_tbl_normal, ma_device, ma_walk, tr_valid, tr_ns;
  logic tr_abort, tr_instr, tr_hw_update, bus_device, bus_cacheable, bus_outer_alloc;
  logic mr_valid, mr_normal, mr_excl, mr_ecc_err, sync_abort, async_abort;
  logic [3:0] tc_perm, tr_perm;
  logic [`HW_ATTR_BITS-1:0] ma_hw_attr_s1, ma_hw_attr_s2, bus_hw_attr;
  logic [5:0] tc_fsc, data_fault_status_code, instr_fault_status_code;
  tc_src_t tc_src, tr_src;
  cache_t tc_tbl_inner, tc_tbl_outer, ma_inner, ma_outer;
  dev_t ma_dev_type, bus_dev_type;
  share_t ma_share, bus_share;
  mem_op_t mr_op;
  chi_resp_t mr_resp;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  // Attribute cases: device, type, inner, outer, share, then cacheable, alloc, share out.
  localparam logic [12:0] attr_tab [12] = '{
    {1'b1, D_NGNRNE, C_NC, C_NC, SH_NON, 2'b00, SH_OUTER},
    {1'b1, D_NGNRE, C_NC, C_NC, SH_INNER, 2'b00, SH_OUTER},
    {1'b1, D_NGRE, C_NC, C_NC, SH_NON, 2'b00, SH_OUTER},
    {1'b1, D_GRE, C_NC, C_NC, SH_NON, 2'b00, SH_OUTER},
    {1'b0, D_NGNRNE, C_NC, C_WB_AL, SH_NON, 2'b00, SH_OUTER},
    {1'b0, D_NGNRNE, C_WT, C_WB_AL, SH_NON, 2'b00, SH_OUTER},
    {1'b0, D_NGNRNE, C_WB_AL, C_NC, SH_NON, 2'b00, SH_OUTER},
    {1'b0, D_NGNRNE, C_WB_NA, C_WT, SH_INNER, 2'b00, SH_OUTER},
    {1'b0, D_NGNRNE, C_WB_AL, C_WB_NA, SH_NON, 2'b10, SH_NON},
    {1'b0, D_NGNRNE, C_WB_NA, C_WB_NA, SH_OUTER, 2'b10, SH_OUTER},
    {1'b0, D_NGNRNE, C_WB_AL, C_WB_AL, SH_INNER, 2'b11, SH_OUTER},
    {1'b0, D_NGNRNE, C_WB_NA, C_WB_AL, SH_OUTER, 2'b11, SH_OUTER}};
  // Memory responses: op, normal, excl, code, ecc, then sync and async expected.
  localparam logic [10:0] ext_tab [22] = '{
    {OP_WALK, 2'b00, R_DERR, 3'b010}, {OP_LOAD, 2'b10, R_NDERR, 3'b010},
    {OP_LOAD, 2'b00, R_DERR, 3'b001}, {OP_LOAD_ACQ, 2'b00, R_DERR, 3'b010},
    {OP_ATOM_LD, 2'b00, R_NDERR, 3'b010}, {OP_ATOM_CAS, 2'b10, R_DERR, 3'b010},
    {OP_ATOM_SWP, 2'b00, R_DERR, 3'b010}, {OP_STORE, 2'b10, R_NDERR, 3'b001},
    {OP_ATOM_ST, 2'b10, R_NDERR, 3'b001}, {OP_CMO, 2'b10, R_DERR, 3'b001},
    {OP_TLB_INV, 2'b00, R_DERR, 3'b001}, {OP_IC, 2'b10, R_NDERR, 3'b001},
    {OP_LOAD, 2'b10, R_OK, 3'b110}, {OP_STORE, 2'b00, R_OK, 3'b101},
    {OP_LOAD, 2'b10, R_OK, 3'b000}, {OP_LOAD, 2'b11, R_OK, 3'b010},
    {OP_LOAD, 2'b11, R_EXOK, 3'b000}, {OP_LOAD, 2'b01, R_OK, 3'b001},
    {OP_STORE, 2'b11, R_EXOK, 3'b000}, {OP_STORE, 2'b11, R_OK, 3'b000},
    {OP_STORE, 2'b11, R_NDERR, 3'b001}, {OP_STORE, 2'b01, R_DERR, 3'b001}};
  // Block under test and the interconnect that answers it.
  mmu_attr_abort dut_u (.*);
  ic_resp_model mem_u (.*);
  // Free-running clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // The whole run needs well under a thousand cycles; a hang is cut short here.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch++;
      close_out();
    end
  end
  // Verdict and end of run.
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compare one value; four-state compare so an unknown never matches.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for an answer that never comes.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Raise one completion at the current edge and let its answer land.
  task automatic fire();
    tc_valid <= 1'b1;
    @(posedge pclk);
    tc_valid <= 1'b0;
    #1;
    check(tr_valid, 1'b1);
  endtask
  // Every abort class, with prompt and slow answers; capture only on sync aborts.
  task automatic s_ext();
    logic [31:0] last;
    last = 32'h0;
    for (int i = 0; i < 22; i++) begin
      mem_u.respond(ext_tab[i], 32'h4000_0100 + 32'(i * 8), i % 2);
      #1;
      check({sync_abort, async_abort}, ext_tab[i][1:0]);
      if (ext_tab[i][1]) last = 32'h4000_0100 + 32'(i * 8);
      check(fault_address_capture, last);
    end
    apb(1'b0, `OFF_FADDR, 32'h0);
    check({er, rd}, {1'b0, last});
    apb(1'b0, `OFF_STATUS, 32'h0);
    check({er, rd}, {1'b0, 32'h0000_0003});
    apb(1'b1, `OFF_STATUS, 32'h0000_0003);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd, 32'h0000_0000);
  endtask
  // Table updates: allowed, refused for data and fetch, gated by controls.
  task automatic s_update();
    apb(1'b1, `OFF_CTRL, 32'h0000_000f);
    @(posedge pclk);
    tc_upd_af <= 1'b1;
    fire();
    check({tr_hw_update, tr_abort}, 2'b10);
    @(posedge pclk);
    tc_tbl_inner <= C_NC;
    fire();
    check({tr_hw_update, tr_abort, data_fault_status_code}, {2'b01, `FSC_HW_UPD_REFUSED});
    @(posedge pclk);
    tc_tbl_inner <= C_WB_AL;
    tc_tbl_outer <= C_WT;
    tc_fetch <= 1'b1;
    fire();
    check({tr_abort, tr_instr, instr_fault_status_code}, {2'b11, `FSC_HW_UPD_REFUSED});
    @(posedge pclk);
    tc_tbl_outer <= C_WB_NA;
    tc_fetch <= 1'b0;
    tc_upd_af <= 1'b0;
    tc_upd_dirty <= 1'b1;
    fire();
    check(tr_hw_update, 1'b0);
    @(posedge pclk);
    tc_dirty_bit_modifier <= 1'b1;
    fire();
    check(tr_hw_update, 1'b1);
    @(posedge pclk);
    tc_tbl_normal <= 1'b0;
    fire();
    check({tr_hw_update, tr_abort}, 2'b01);
    apb(1'b1, `OFF_CTRL, 32'h0000_0003);
    @(posedge pclk);
    tc_tbl_normal <= 1'b1;
    tc_stage2 <= 1'b1;
    fire();
    check(tr_hw_update, 1'b0);
  endtask
  // Every completion source, fields carried, walker faults raised.
  task automatic s_resp();
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      tc_upd_dirty <= 1'b0;
      tc_src <= tc_src_t'(i);
      tc_pa <= 32'h8000_0000 | 32'(i * 4096);
      tc_perm <= 4'(i + 9);
      tc_ns <= i[0];
      tc_fault <= i[1];
      tc_fsc <= 6'(i + 4);
      fire();
      check({tr_src, tr_perm, tr_ns}, {2'(i), 4'(i + 9), i[0]});
      check(tr_pa, 32'h8000_0000 | 32'(i * 4096));
      check(tr_abort, i[1]);
      if (i[1]) check(data_fault_status_code, 6'(i + 4));
    end
    @(posedge pclk);
    tc_fault <= 1'b0;
    #1;
    check({tr_valid, tr_hw_update}, 2'b00);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd, 32'h0000_0700);
  endtask
  // Memory type and shareability mapping over the whole case table.
  task automatic s_attr();
    logic [12:0] e;
    for (int i = 0; i < 12; i++) begin
      e = attr_tab[i];
      @(posedge pclk);
      ma_device <= e[12];
      ma_dev_type <= dev_t'(e[11:10]);
      ma_inner <= cache_t'(e[9:8]);
      ma_outer <= cache_t'(e[7:6]);
      ma_share <= share_t'(e[5:4]);
      fire();
      check({bus_device, bus_cacheable, bus_share}, {e[12], e[3], e[1:0]});
      if (e[12]) check(bus_dev_type, e[11:10]);
      if (e[3]) check(bus_outer_alloc, e[2]);
    end
  endtask
  // Attribute bits: disabled, per-bit stage merge, stage 1 only, walk controls.
  task automatic s_hw_attr();
    apb(1'b1, `OFF_CTRL, 32'h0000_ff00);
    apb(1'b1, `OFF_WALK, 32'h0000_00c3);
    apb(1'b0, `OFF_WALK, 32'h0);
    check({er, rd}, {1'b0, 32'h0000_00c3});
    @(posedge pclk);
    // One mapping per address, so the bits never disagree between aliases.
    ma_hw_attr_s1 <= 4'hf;
    ma_hw_attr_s2 <= 4'h1;
    fire();
    check(bus_hw_attr, 4'h0);
    apb(1'b1, `OFF_CTRL, 32'h0000_3610);
    @(posedge pclk);
    fire();
    check(bus_hw_attr, 4'h5);
    @(posedge pclk);
    tc_stage2 <= 1'b0;
    fire();
    check(bus_hw_attr, 4'h6);
    @(posedge pclk);
    ma_walk <= 1'b1;
    fire();
    check(bus_hw_attr, 4'h3);
    @(posedge pclk);
    tc_stage2 <= 1'b1;
    fire();
    check(bus_hw_attr, 4'hc);
  endtask
  // Main sequence: quiet inputs, reset, register checks, then every scenario.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, tc_valid, tc_fetch, tc_pa, tc_perm, tc_ns} = '0;
    {tc_fault, tc_fsc, tc_stage2, tc_upd_af, tc_upd_dirty, tc_dirty_bit_modifier} = '0;
    {ma_device, ma_walk, ma_hw_attr_s1, ma_hw_attr_s2, presetn} = '0;
    tc_tbl_normal = 1'b1;
    tc_src = SRC_L1I;
    tc_tbl_inner = C_WB_AL;
    tc_tbl_outer = C_WB_AL;
    ma_dev_type = D_NGNRNE;
    ma_inner = C_NC;
    ma_outer = C_NC;
    ma_share = SH_NON;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check({tr_valid, sync_abort, async_abort, bus_share, bus_hw_attr, fault_address_capture}, 0);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    check(er, 1'b1);
    apb(1'b0, `OFF_CTRL, 32'h0);
    check({er, rd}, {1'b0, `CTRL_RESET});
    s_ext();
    s_update();
    s_resp();
    s_attr();
    s_hw_attr();
    close_out();
  end
endmodule
